/* rtl/cci_params.svh */
`ifndef CCI_PARAMS_SVH
`define CCI_PARAMS_SVH

// Comparator output bit positions in the control register
`define CCI_OUT_TWO_BIT      7
`define CCI_OUT_ONE_BIT      6
// Reset values
`define CCI_FLAG_RST         1'h0
`define CCI_LATCH_RST        2'h0
// Depth of pin synchroniser
`define CCI_SYNC_STAGES      2

`endif

/* rtl/cci_pkg.sv */
`default_nettype none
package cci_pkg;
    `include "cci_params.svh"

    // Pair of comparator outputs, bit 1 = comparator two, bit 0 = comparator one
    typedef logic [1:0] cci_outs_t;

    // Register access from the core
    typedef struct packed {
        logic rd;        // Read of comparator control register
        logic wr;        // Write of comparator control register
    } cci_ctl_acc_t;

    // Flag register access from the core
    typedef struct packed {
        logic wr;        // Write strobe of the flag bit
        logic data;      // Value written
    } cci_flag_acc_t;

    // Three interrupt enables
    typedef struct packed {
        logic change_en; // Comparator change enable
        logic periph_en; // Peripheral interrupt enable
        logic global_en; // Global interrupt enable
    } cci_en_t;
endpackage
`default_nettype wire

/* rtl/cci_sync.sv */
`default_nettype none
module cci_sync
    import cci_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      rst_n,
    // Asynchronous pins in, synchronised out
    input  wire cci_pkg::cci_outs_t async_in,
    output var  cci_pkg::cci_outs_t sync_out
);
    import cci_pkg::*;

    // First stage is read only by the second
    cci_outs_t meta;

    // Two-flop synchroniser for comparator outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta     <= `CCI_LATCH_RST;
            sync_out <= `CCI_LATCH_RST;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

/* rtl/cci_top.sv */
`include "cci_params.svh"
`default_nettype none
module cci_top
    import cci_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rst_n,
    // Comparator outputs, asynchronous
    input  wire cci_pkg::cci_outs_t     cmp_out_async,
    // Core access strobes
    input  wire cci_pkg::cci_ctl_acc_t  ctl_acc,
    input  wire cci_pkg::cci_flag_acc_t flag_acc,
    // Interrupt enables
    input  wire cci_pkg::cci_en_t       enables,
    // Status and interrupt
    output var  cci_pkg::cci_outs_t     cmp_out_read,
    output logic                        comparator_change_flag,
    output logic                        cmp_irq
);
    import cci_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Inputs
    cci_outs_t live;       // Synchronised comparator outputs
    cci_outs_t latched;    // Copy taken at last access
    logic      mismatch;   // Live differs from copy
    logic      access;     // Any read or write of control register

    // Pins cross into mclk domain first
    cci_sync u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (cmp_out_async),
        .sync_out (live)
    );

    // Compare against copy each clock
    assign mismatch = (live != latched);
    // Reads and writes count alike; both reload the copy
    assign access   = ctl_acc.rd | ctl_acc.wr;

    ////////////////////////////////////////////////////////////////////////
    // Latched copy
    // Reloaded on any access; this ends the mismatch on the next edge unless the outputs move at that edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latched <= `CCI_LATCH_RST;
        end else if (access) begin
            latched <= live;
        end
    end

    // Readback of control register output bits comes from the copy source
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmp_out_read <= `CCI_LATCH_RST;
        end else begin
            cmp_out_read <= live;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag
    // Hardware set beats software clear, so a mismatch seen in the clear
    // cycle is never lost. A change landing exactly with an access is
    // absorbed into the copy and does not set the flag, a narrow miss window.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            comparator_change_flag <= `CCI_FLAG_RST;
        end else if (mismatch && !access) begin
            comparator_change_flag <= 1'b1;
        end else if (flag_acc.wr) begin
            comparator_change_flag <= flag_acc.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gating, combinational handshake output
    // One place for the enable decode, shared by the logic and its check
    function automatic logic all_enabled(input cci_en_t en);
        return en.change_en & en.periph_en & en.global_en;
    endfunction

    // Flag alone never reaches the core; any clear enable masks it
    assign cmp_irq = comparator_change_flag & all_enabled(enables);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // All properties sample on the rising edge and sleep while in reset
    // Set lands one edge after the mismatch is seen
    property p_set_on_mismatch;
        @(posedge mclk) disable iff (!rst_n)
        (mismatch && !access) |=> comparator_change_flag;
    endproperty
    a_set_on_mismatch: assert property (p_set_on_mismatch)
        else $error("flag not set after mismatch");

    property p_clear_write;
        @(posedge mclk) disable iff (!rst_n)
        (flag_acc.wr && !flag_acc.data && !mismatch) |=> !comparator_change_flag;
    endproperty
    a_clear_write: assert property (p_clear_write)
        else $error("flag not cleared by write of zero");

    // Only a write may lower the flag
    property p_sticky;
        @(posedge mclk) disable iff (!rst_n)
        (comparator_change_flag && !flag_acc.wr) |=> comparator_change_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a write");

    // Software set works even with no mismatch
    property p_soft_set;
        @(posedge mclk) disable iff (!rst_n)
        (flag_acc.wr && flag_acc.data) |=> comparator_change_flag;
    endproperty
    a_soft_set: assert property (p_soft_set)
        else $error("software set failed");

    property p_irq_gate;
        @(posedge mclk) disable iff (!rst_n)
        cmp_irq == (comparator_change_flag && enables.change_en
                    && enables.periph_en && enables.global_en);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt gating wrong");

    property p_set_disabled;
        @(posedge mclk) disable iff (!rst_n)
        (mismatch && !access && !enables.global_en) |=> comparator_change_flag;
    endproperty
    a_set_disabled: assert property (p_set_disabled)
        else $error("flag not set while disabled");

    // Holds only when the outputs sit still across the access
    property p_access_ends;
        @(posedge mclk) disable iff (!rst_n)
        access ##1 $stable(live) |-> !mismatch;
    endproperty
    a_access_ends: assert property (p_access_ends)
        else $error("access did not end mismatch");

    // A clear racing a live mismatch must lose
    property p_reset_flag;
        @(posedge mclk) disable iff (!rst_n)
        (mismatch && !access && flag_acc.wr && !flag_acc.data)
            |=> comparator_change_flag;
    endproperty
    a_reset_flag: assert property (p_reset_flag)
        else $error("mismatch did not win over clear");

    // Nothing sets the flag out of thin air
    property p_no_set_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (!comparator_change_flag && !mismatch && !flag_acc.wr)
            |=> !comparator_change_flag;
    endproperty
    a_no_set_quiet: assert property (p_no_set_quiet)
        else $error("flag set without cause");

    // Copy must take exactly the value seen at the access edge
    property p_latch_on_access;
        @(posedge mclk) disable iff (!rst_n)
        access |=> (latched == $past(live));
    endproperty
    a_latch_on_access: assert property (p_latch_on_access)
        else $error("copy not reloaded on access");

    // Without an access the copy must not drift, or changes would be lost
    property p_latch_hold;
        @(posedge mclk) disable iff (!rst_n)
        !access |=> $stable(latched);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("copy changed without access");

    // A change swallowed by an access leaves a clear flag clear
    property p_miss_window;
        @(posedge mclk) disable iff (!rst_n)
        (mismatch && access && !flag_acc.wr && !comparator_change_flag)
            |=> !comparator_change_flag;
    endproperty
    a_miss_window: assert property (p_miss_window)
        else $error("flag set inside the miss window");

    // Readback trails the synchronised outputs by one register
    property p_readback;
        @(posedge mclk) disable iff (!rst_n)
        cmp_out_read == $past(live);
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback does not follow comparator outputs");

    // Any clear enable keeps the core request low
    property p_irq_masked;
        @(posedge mclk) disable iff (!rst_n)
        !all_enabled(enables) |-> !cmp_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt passed a clear enable");

    c_change: cover property (@(posedge mclk) disable iff (!rst_n)
        !comparator_change_flag ##1 comparator_change_flag);
    c_irq: cover property (@(posedge mclk) disable iff (!rst_n) cmp_irq);
    c_service: cover property (@(posedge mclk) disable iff (!rst_n)
        comparator_change_flag ##1 access ##1 (flag_acc.wr && !flag_acc.data)
        ##1 !comparator_change_flag);
    // Software set and the miss window
    c_soft_set: cover property (@(posedge mclk) disable iff (!rst_n)
        flag_acc.wr && flag_acc.data && !comparator_change_flag);
    c_miss: cover property (@(posedge mclk) disable iff (!rst_n)
        mismatch && access && !comparator_change_flag);
endmodule
`default_nettype wire

/* test/cci_core_model.sv */
`default_nettype none
module cci_core_model (
    // Clock and interrupt from the block
    input  wire logic mclk,
    input  wire logic irq,
    input  wire logic active,
    // Service strobes towards the block
    output logic      rd_pulse = 1'b0,
    output logic      clr_pulse = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // Service routine: read control first, clear flag one cycle later.
    // The clear never comes before the read, or the mismatch would re-set it.
    always @(negedge mclk) begin
        clr_pulse <= rd_pulse;
        rd_pulse  <= active && irq && !rd_pulse && !clr_pulse;
    end
endmodule
`default_nettype wire

/* test/tb_cci_top.sv */
`default_nettype none
module tb_cci_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cci_pkg::*;
    logic          mclk = 0, rst_n = 0, flag, irq, svc_on = 0, s_rd, s_clr;
    cci_outs_t     pins = '0, rd_val, nv, prev;
    cci_ctl_acc_t  acc = '0, acc_m;
    cci_flag_acc_t fa = '0, fa_m;
    cci_en_t       en = '0;
    int            n_mismatch = 0, comparisons = 0;
    // Bench strobes merged with the service model
    assign acc_m = {acc.rd | s_rd, acc.wr};
    assign fa_m  = {fa.wr | s_clr, fa.data & ~s_clr};
    always #12.5 mclk = ~mclk;
    cci_top i_cci_top (.mclk(mclk), .rst_n(rst_n), .cmp_out_async(pins), .ctl_acc(acc_m),
        .flag_acc(fa_m), .enables(en), .cmp_out_read(rd_val),
        .comparator_change_flag(flag), .cmp_irq(irq));
    cci_core_model i_cci_core_model (.mclk(mclk), .irq(irq), .active(svc_on),
        .rd_pulse(s_rd), .clr_pulse(s_clr));
    ////////////////////////////////////////////////////////////////////////
    // Expectations
    function automatic logic exp_flag(input cci_outs_t o, input cci_outs_t n);
        return o != n;
    endfunction
    function automatic logic exp_irq(input logic f, input logic [2:0] e);
        return f & (&e);
    endfunction
    // Helpers
    task automatic edges(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic tally(input logic bad, input string what);
        comparisons++;
        if (bad) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        tally(got !== exp, $sformatf("flag got %b expected %b", got, exp));
    endtask
    task automatic check_irq(input logic got, input logic exp);
        tally(got !== exp, $sformatf("interrupt got %b expected %b", got, exp));
    endtask
    task automatic check_read(input cci_outs_t got, input cci_outs_t exp);
        tally(got !== exp, $sformatf("readback got %b expected %b", got, exp));
    endtask
    task automatic write_flag(input logic v);
        fa = '{wr: 1'b1, data: v};
        edges(1);
        fa = '0;
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h0b96_cfdb));
        edges(10);
        rst_n = 1;
        check_flag(flag, 1'b0);
        check_irq(irq, 1'b0);
        pins = 2'b10;
        edges(3);
        check_flag(flag, 1'b1);
        check_read(rd_val, 2'b10);
        write_flag(1'b0);
        check_flag(flag, 1'b1);
        acc.rd = 1'b1;
        edges(1);
        acc = '0;
        write_flag(1'b0);
        check_flag(flag, 1'b0);
        edges(1);
        write_flag(1'b1);
        check_flag(flag, 1'b1);
        for (int i = 0; i < 8; i++) begin
            en = cci_en_t'(i[2:0]);
            edges(1);
            check_irq(irq, exp_irq(1'b1, i[2:0]));
        end
        en = '0;
        write_flag(1'b0);
        // Random changes, each serviced by read or write
        for (int k = 0; k < 20; k++) begin
            prev = pins;
            nv = cci_outs_t'($urandom);
            pins = nv;
            edges(3);
            check_flag(flag, exp_flag(prev, nv));
            check_read(rd_val, nv);
            if (k % 2 == 1)
                acc = cci_ctl_acc_t'{rd: 1'b0, wr: 1'b1};
            else
                acc = cci_ctl_acc_t'{rd: 1'b1, wr: 1'b0};
            edges(1);
            acc = '0;
            write_flag(1'b0);
            check_flag(flag, 1'b0);
        end
        // Change landing on a control read is lost
        pins = ~pins;
        edges(2);
        acc.rd = 1'b1;
        edges(1);
        acc = '0;
        check_flag(flag, 1'b0);
        edges(2);
        check_flag(flag, 1'b0);
        // Service model clears a live interrupt
        en = '1;
        svc_on = 1;
        pins = ~pins;
        edges(3);
        check_irq(irq, 1'b1);
        edges(5);
        check_flag(flag, 1'b0);
        check_irq(irq, 1'b0);
        complete_run;
    end
    // Watchdog
    initial begin
        #(5000 * 25);
        n_mismatch++;
        complete_run;
    end
endmodule
`default_nettype wire
